// File: design/asr_defines.svh
// timing and reset constants for the static memory host controller
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

`define ASR_CLK_NS       20
`define ASR_TWP_NS       40
`define ASR_TAA_NS       55
`define ASR_TWP_CYC      ((`ASR_TWP_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_TAA_CYC      ((`ASR_TAA_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_SYNC_STAGES  2
`define ASR_CNT_W        3
`define ASR_PIN_IDLE     1'b1
`define ASR_LANES_OFF    2'h3
`define ASR_WORD_ZERO    16'h0000
`define ASR_ADDR_ZERO    17'h00000

`endif

// File: design/asr_host.sv
// host controller driving a 128K x 16 asynchronous static memory
`timescale 1ns/100ps
`include "asr_defines.svh"
module asr_host
  import asr_pkg::*;
(
  input  wire logic            MCLK,        // 50 MHz clock
  input  wire logic            RESET_N,     // async reset, active low
  input  wire logic            CE,          // clock enable, freezes state when low
  input  wire logic            REQ_VALID,   // request present
  output logic                 REQ_READY,   // request taken when both high
  input  wire logic            REQ_WRITE,   // 1 write, 0 read
  input  wire asr_pkg::asr_addr_t REQ_ADDR, // word address
  input  wire asr_pkg::asr_data_t REQ_WDATA,// write data
  input  wire asr_pkg::asr_lane_t REQ_BE,   // lane enables, bit0 low lane
  output logic                 RSP_VALID,   // one-cycle completion pulse
  output asr_pkg::asr_data_t   RSP_RDATA,   // read data
  output asr_pkg::asr_addr_t   WORD_ADDRESS,       // memory word address pins
  output logic                 SEL_N,              // device select, active low
  output logic                 OUT_DRIVE_N,        // output drive, active low
  output logic                 WRITE_STROBE_N,     // write strobe, active low
  output logic                 LOW_LANE_ENABLE_N,  // low lane enable
  output logic                 HIGH_LANE_ENABLE_N, // high lane enable
  input  wire asr_pkg::asr_data_t DATA_LANES_I,    // data lanes from pins
  output asr_pkg::asr_data_t   DATA_LANES_O,       // data lanes to pins
  output logic                 DATA_LANES_OE       // high while host drives lanes
);
  import asr_pkg::*;

  asr_state_t                state_reg;
  logic [`ASR_CNT_W-1:0]     cnt_reg;
  asr_data_t                 rd_sync;
  logic                      take;

  assign REQ_READY = CE && (state_reg == ASR_IDLE);
  assign take      = REQ_READY && REQ_VALID;

  // read data comes from pins, so it is synchronised before use
  asr_sync #(
    .WIDTH ($bits(asr_data_t))
  ) u_rd_sync (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .ce    (CE),
    .d     (DATA_LANES_I),
    .q     (rd_sync)
  );

  // sequencing of each access
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_reg <= ASR_IDLE;
      cnt_reg   <= '0;
    end
    else if (CE)
    begin
      unique case (state_reg)
        ASR_IDLE:
        begin
          if (take && REQ_WRITE)
            state_reg <= ASR_WSETUP;
          else if (take)
          begin
            state_reg <= ASR_RACC;
            // access time plus the synchroniser delay
            cnt_reg   <= `ASR_CNT_W'(`ASR_TAA_CYC + `ASR_SYNC_STAGES - 1);
          end
        end
        ASR_WSETUP:
        begin
          state_reg <= ASR_WPULSE;
          cnt_reg   <= `ASR_CNT_W'(`ASR_TWP_CYC - 1);
        end
        ASR_WPULSE:
        begin
          if (cnt_reg == '0)
            state_reg <= ASR_WHOLD;
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        ASR_WHOLD:
          state_reg <= ASR_IDLE;
        ASR_RACC:
        begin
          if (cnt_reg == '0)
            state_reg <= ASR_IDLE;
          else
            cnt_reg <= cnt_reg - 1'b1;
        end
        default:
          state_reg <= ASR_IDLE;
      endcase
    end
  end

  // address and lanes latched at take and held through the hold cycle
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      WORD_ADDRESS       <= `ASR_ADDR_ZERO;
      LOW_LANE_ENABLE_N  <= `ASR_PIN_IDLE;
      HIGH_LANE_ENABLE_N <= `ASR_PIN_IDLE;
      DATA_LANES_O       <= `ASR_WORD_ZERO;
    end
    else if (CE)
    begin
      if (take)
      begin
        WORD_ADDRESS       <= REQ_ADDR;
        DATA_LANES_O       <= REQ_WDATA;
        // no enabled lane would deselect the device, so treat it as a word
        LOW_LANE_ENABLE_N  <= ~(REQ_BE[0] || (REQ_BE == 2'h0));
        HIGH_LANE_ENABLE_N <= ~(REQ_BE[1] || (REQ_BE == 2'h0));
      end
      else if (state_reg == ASR_WHOLD || (state_reg == ASR_RACC && cnt_reg == '0))
      begin
        LOW_LANE_ENABLE_N  <= `ASR_PIN_IDLE;
        HIGH_LANE_ENABLE_N <= `ASR_PIN_IDLE;
      end
    end
  end

  // control strobes, all registered so they never glitch
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      SEL_N          <= `ASR_PIN_IDLE;
      OUT_DRIVE_N    <= `ASR_PIN_IDLE;
      WRITE_STROBE_N <= `ASR_PIN_IDLE;
      DATA_LANES_OE  <= 1'b0;
    end
    else if (CE)
    begin
      if (take)
      begin
        SEL_N         <= 1'b0;
        OUT_DRIVE_N   <= REQ_WRITE;
        DATA_LANES_OE <= REQ_WRITE;
      end
      else if (state_reg == ASR_WSETUP)
        WRITE_STROBE_N <= 1'b0;
      else if (state_reg == ASR_WPULSE && cnt_reg == '0)
      begin
        // both rise together; the address still stands at least two more cycles
        WRITE_STROBE_N <= `ASR_PIN_IDLE;
        SEL_N          <= `ASR_PIN_IDLE;
      end
      else if (state_reg == ASR_WHOLD)
        DATA_LANES_OE <= 1'b0;
      else if (state_reg == ASR_RACC && cnt_reg == '0)
      begin
        SEL_N       <= `ASR_PIN_IDLE;
        OUT_DRIVE_N <= `ASR_PIN_IDLE;
      end
    end
  end

  // completion pulse and captured read data
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= `ASR_WORD_ZERO;
    end
    else if (CE)
    begin
      RSP_VALID <= (state_reg == ASR_WHOLD) || (state_reg == ASR_RACC && cnt_reg == '0);
      if (state_reg == ASR_RACC && cnt_reg == '0)
        RSP_RDATA <= rd_sync;
    end
  end

  a_addr_stable_wr: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    (!WRITE_STROBE_N && !SEL_N) |-> $stable(WORD_ADDRESS))
    else $error("address moved during a write");

  a_addr_hold_end: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    (CE && $rose(WRITE_STROBE_N)) |-> $stable(WORD_ADDRESS) ##1 $stable(WORD_ADDRESS))
    else $error("address changed at end of write");

  a_lane_write_set: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    !WRITE_STROBE_N |-> !(LOW_LANE_ENABLE_N && HIGH_LANE_ENABLE_N))
    else $error("write strobe low with no lane enabled");

  a_strobe_pulse_len: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    (CE && $fell(WRITE_STROBE_N)) |-> (!WRITE_STROBE_N && !SEL_N && CE) [*2]
      or (!CE ##0 1'b1))
    else $error("write pulse shorter than two cycles");

  a_idle_pins_high: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    (state_reg == ASR_IDLE) |-> (SEL_N && WRITE_STROBE_N && OUT_DRIVE_N))
    else $error("control pins active while idle");

  a_no_drive_clash: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    DATA_LANES_OE |-> OUT_DRIVE_N)
    else $error("host drives lanes while memory drives them");

  a_read_latency: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    (CE && $fell(OUT_DRIVE_N)) ##1 CE [*4] |-> ##1 RSP_VALID)
    else $error("read response not after five cycles");

  a_write_end_pair: assert property (
    @(posedge MCLK) disable iff (!RESET_N)
    $rose(WRITE_STROBE_N) |-> $rose(SEL_N))
    else $error("strobe and select did not end write together");

endmodule : asr_host

// File: design/asr_pkg.sv
// types shared by the static memory host controller
package asr_pkg;
  typedef enum logic [5:0] {
    ASR_IDLE   = 6'h01,
    ASR_WSETUP = 6'h02,
    ASR_WPULSE = 6'h04,
    ASR_WHOLD  = 6'h08,
    ASR_RACC   = 6'h10,
    ASR_SPARE  = 6'h20
  } asr_state_t;
  typedef logic [16:0] asr_addr_t;
  typedef logic [15:0] asr_data_t;
  typedef logic [1:0]  asr_lane_t;
endpackage : asr_pkg

// File: design/asr_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module asr_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,   // system clock
  input  wire logic             rst_n, // async reset, active low
  input  wire logic             ce,    // clock enable
  input  wire logic [WIDTH-1:0] d,     // asynchronous input
  output logic      [WIDTH-1:0] q      // synchronised output
);
  logic [WIDTH-1:0] meta_reg;

  // meta_reg feeds only q
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else if (ce)
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : asr_sync

// File: tb/asr_host_tb.sv
// self-checking bench for the static memory host controller
`timescale 1ns/100ps
module asr_host_tb;
  import asr_pkg::*;
  typedef struct packed {
    logic      wr;
    asr_addr_t a;
    asr_data_t d;
    asr_lane_t be;
    asr_data_t exp;
  } asr_row_t;
  logic      MCLK = 1'b0;
  logic      RESET_N = 1'b0;
  logic      CE = 1'b1;
  logic      REQ_VALID = 1'b0;
  logic      REQ_WRITE = 1'b0;
  asr_addr_t REQ_ADDR = 17'h0;
  asr_data_t REQ_WDATA = 16'h0;
  asr_lane_t REQ_BE = 2'h0;
  logic      REQ_READY, RSP_VALID, SEL_N, OUT_DRIVE_N, WRITE_STROBE_N, w_prev;
  logic      LOW_LANE_ENABLE_N, HIGH_LANE_ENABLE_N, DATA_LANES_OE;
  asr_data_t RSP_RDATA, DATA_LANES_I, DATA_LANES_O, mem_q;
  asr_addr_t WORD_ADDRESS, a_prev;
  asr_lane_t mem_en;
  logic [4:0] ctl_pins;
  int        error_cnt = 0;
  int        samples_checked = 0;
  asr_row_t  rows [11];

  always #10 MCLK = ~MCLK;
  assign DATA_LANES_I = DATA_LANES_OE ? DATA_LANES_O : mem_q;
  assign ctl_pins = {SEL_N, OUT_DRIVE_N, WRITE_STROBE_N, LOW_LANE_ENABLE_N, HIGH_LANE_ENABLE_N};

  asr_host u_dut (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
    .REQ_BE(REQ_BE), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .WORD_ADDRESS(WORD_ADDRESS),
    .SEL_N(SEL_N), .OUT_DRIVE_N(OUT_DRIVE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
    .LOW_LANE_ENABLE_N(LOW_LANE_ENABLE_N), .HIGH_LANE_ENABLE_N(HIGH_LANE_ENABLE_N),
    .DATA_LANES_I(DATA_LANES_I), .DATA_LANES_O(DATA_LANES_O), .DATA_LANES_OE(DATA_LANES_OE));

  asr_mem_model u_mem (.sel_n(SEL_N), .oe_n(OUT_DRIVE_N), .we_n(WRITE_STROBE_N),
    .lane_n({HIGH_LANE_ENABLE_N, LOW_LANE_ENABLE_N}), .addr(WORD_ADDRESS),
    .din(DATA_LANES_O), .dout(mem_q), .dout_en(mem_en));

  task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic do_req(input asr_row_t r, output asr_data_t rd, output int lat);
    @(posedge MCLK);
    REQ_VALID <= 1'b1;
    REQ_WRITE <= r.wr;
    REQ_ADDR  <= r.a;
    REQ_WDATA <= r.d;
    REQ_BE    <= r.be;
    do @(negedge MCLK); while (REQ_READY !== 1'b1);
    @(posedge MCLK);
    REQ_VALID <= 1'b0;
    lat = 0;
    do
    begin
      @(negedge MCLK);
      lat++;
    end
    while (RSP_VALID !== 1'b1 && lat < 20);
    rd = RSP_RDATA;
  endtask : do_req

  // host must never drive while the memory drives, and must hold the address
  always @(negedge MCLK)
  begin
    if (RESET_N)
      check("lane contention", 17'h0, {16'h0, DATA_LANES_OE && mem_en != 2'h0});
    if (w_prev) check("address hold", a_prev, WORD_ADDRESS);
    w_prev <= !SEL_N && !WRITE_STROBE_N;
    a_prev <= WORD_ADDRESS;
  end

  initial
  begin
    repeat (2000) @(posedge MCLK);
    error_cnt++;
    final_report();
  end

  initial
  begin
    asr_row_t  r;
    asr_data_t rd, m;
    int        lat;
    rows = '{'{1'b1, 17'h00000, 16'h1234, 2'h3, 16'h0}, '{1'b1, 17'h1ffff, 16'habcd, 2'h3, 16'h0},
      '{1'b0, 17'h00000, 16'h0, 2'h3, 16'h1234}, '{1'b0, 17'h1ffff, 16'h0, 2'h3, 16'habcd},
      '{1'b1, 17'h1ffff, 16'h5500, 2'h1, 16'h0}, '{1'b1, 17'h00000, 16'h99ff, 2'h2, 16'h0},
      '{1'b0, 17'h1ffff, 16'h0, 2'h1, 16'hab00}, '{1'b0, 17'h1ffff, 16'h0, 2'h2, 16'hab00},
      '{1'b0, 17'h00000, 16'h0, 2'h3, 16'h9934}, '{1'b1, 17'h00010, 16'h0f0f, 2'h0, 16'h0},
      '{1'b0, 17'h00010, 16'h0, 2'h3, 16'h0f0f}};
    repeat (10) @(posedge MCLK);
    RESET_N <= 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      do_req(r, rd, lat);
      m = {{8{r.be[1] || r.be == 2'h0}}, {8{r.be[0] || r.be == 2'h0}}};
      // counted at falling edges: one more than the edges from take to response
      check("latency", r.wr ? 17'h5 : 17'h6, 17'(lat));
      if (!r.wr) check("read data", r.exp & m, rd & m);
    end
    @(posedge MCLK);
    CE <= 1'b0;
    REQ_VALID <= 1'b1;
    repeat (3) @(negedge MCLK);
    check("ready while frozen", 17'h0, {16'h0, REQ_READY});
    check("select while frozen", 17'h1, {16'h0, SEL_N});
    @(posedge MCLK);
    CE <= 1'b1;
    REQ_VALID <= 1'b0;
    RESET_N <= 1'b0;
    repeat (3) @(negedge MCLK);
    check("idle pins", 17'h1f, {12'h0, ctl_pins});
    check("lane drive", 17'h0, {16'h0, DATA_LANES_OE});
    @(posedge MCLK);
    RESET_N <= 1'b1;
    do_req(rows[10], rd, lat);
    check("data after reset", 17'h0f0f, rd);
    final_report();
  end
endmodule : asr_host_tb

// File: tb/asr_mem_model.sv
// behavioural model of the 128K x 16 static memory
`timescale 1ns/100ps
module asr_mem_model
  import asr_pkg::*;
(
  input  wire logic      sel_n,  // device select
  input  wire logic      oe_n,   // output drive
  input  wire logic      we_n,   // write strobe
  input  wire asr_lane_t lane_n, // lane enables, bit0 low lane
  input  wire asr_addr_t addr,   // word address
  input  wire asr_data_t din,    // data from host
  output asr_data_t      dout,   // data toward host
  output asr_lane_t      dout_en // lanes driven by memory
);
  asr_data_t mem [0:131071];
  asr_data_t wd;
  asr_addr_t wa;
  asr_lane_t wl;
  logic      wr_on;
  assign wr_on = !sel_n && !we_n;
  assign dout_en = (!sel_n && !oe_n && we_n) ? ~lane_n : 2'h0;
  // a released lane shows the inverse, so sampling it by mistake cannot pass
  assign dout = mem[addr] ^ {{8{!dout_en[1]}}, {8{!dout_en[0]}}};
  always @(*) if (wr_on) {wa, wd, wl} = {addr, din, ~lane_n};
  always @(negedge wr_on)
  begin
    if (wl[0]) mem[wa][7:0] = wd[7:0];
    if (wl[1]) mem[wa][15:8] = wd[15:8];
  end
endmodule : asr_mem_model
